// >>> verilog/spcs_pkg.sv
// Package for the clock-stop serial port: register map, control layout,
// FSM states and timing figures. Assumes a 125 MHz system clock.
package spcs_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int GEN_SRC_DIV_P  = 4;    // CPU periods per generator input
  localparam int SLV_DX_MAX_P   = 16;   // Select low to data valid, CPU periods
  localparam int SLV_DX_MAX_NS  = SLV_DX_MAX_P * CLK_PERIOD_NS;
  localparam int SLV_DX_MAX_CYC = (SLV_DX_MAX_NS / CLK_PERIOD_NS < 1) ? 1
                                  : SLV_DX_MAX_NS / CLK_PERIOD_NS;
  localparam logic [1:0] GEN_TICK_LAST = 2'(GEN_SRC_DIV_P - 1);

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] TXDATA_ADDR = 12'h008;
  localparam logic [11:0] RXDATA_ADDR = 12'h00C;

  // Status bit positions
  localparam int ST_BUSY     = 0;
  localparam int ST_TX_FULL  = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_RX_VALID = 3;
  localparam int ST_RX_FULL  = 4;

  // Clock-stop modes
  localparam logic [1:0] CSTOP_HALF = 2'b10;
  localparam logic [1:0] CSTOP_FULL = 2'b11;
  localparam logic [7:0] SLAVE_DIV  = 8'h01;

  // Control register, bit 0 at the bottom
  typedef struct packed {
    logic       enable;
    logic       receive_select_polarity;
    logic       transmit_select_polarity;
    logic       receive_select_direction;
    logic       transmit_select_direction;
    logic       receive_clock_direction;
    logic       transmit_clock_direction;
    logic       transmit_clock_polarity;
    logic [1:0] clock_stop_mode;
    logic [7:0] generator_divider;
    logic       generator_source_select;
  } spcs_ctrl_t;

  localparam spcs_ctrl_t CTRL_RESET = '0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_TAIL, ST_SLV
  } spcs_state_t;

endpackage

// >>> verilog/spcs_top.sv
// Clock-stop serial port with APB register access, master or slave.
// Assumes APB and all pins synchronous to mclk; the pad ring resolves
// each output enable into the wire level.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// ----------------------------------------
// Two-entry buffer
// ----------------------------------------
module spcs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// Port top
// ----------------------------------------
module spcs_top #(
  parameter int WORD_W = 8,
  parameter int BUF_D  = 2
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              generator_source_clock,
  input  wire logic              transmit_serial_clock,
  output logic                   transmit_serial_clock_drv,
  output logic                   transmit_serial_clock_oe_n,
  input  wire logic              transmit_frame_select,
  output logic                   transmit_frame_select_drv,
  output logic                   transmit_frame_select_oe_n,
  input  wire logic              receive_frame_select,
  output logic                   serial_data_out,
  output logic                   serial_data_out_oe_n,
  input  wire logic              serial_data_in
);
  import spcs_pkg::*;

  spcs_ctrl_t        ctrl_r;
  spcs_state_t       state_r;
  logic [7:0]        cnt_r;
  logic [7:0]        bit_r;
  logic [WORD_W-1:0] tsh_r;
  logic [WORD_W-1:0] rsh_r;
  logic              lvl_r;
  logic              act_r;
  logic              dx_r;
  logic              dx_en_r;
  logic              first_r;
  logic              rx_push_r;
  logic [1:0]        gdiv_r;
  logic              src_prev_r;
  logic              sclk_prev_r;
  logic              pready_r;
  logic              pslverr_r;
  logic [31:0]       prdata_r;
  logic              tx_v;
  logic              tx_pop;
  logic [WORD_W-1:0] tx_d;
  logic              tx_in_rdy;
  logic              tx_in_v;
  logic              rx_v;
  logic              rx_pop;
  logic              rx_rdy;
  logic [WORD_W-1:0] rx_d;
  logic              master;
  logic              eff_src;
  logic [7:0]        eff_div;
  logic [7:0]        hi_len;
  logic [7:0]        lo_len;
  logic [7:0]        per_len;
  logic              tick;
  logic              m11;
  logic              sel;
  logic              rsel;
  logic              s_lvl;
  logic              s_rise;
  logic              s_fall;
  logic              acc;
  logic              last_bit;

  // ----------------------------------------
  // Buffers
  // ----------------------------------------
  spcs_fifo #(.W(WORD_W), .DEPTH(BUF_D)) u_txbuf (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (tx_in_v),
    .in_ready  (tx_in_rdy),
    .in_data   (pwdata[WORD_W-1:0]),
    .out_valid (tx_v),
    .out_ready (tx_pop),
    .out_data  (tx_d)
  );

  spcs_fifo #(.W(WORD_W), .DEPTH(BUF_D)) u_rxbuf (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (rx_push_r),
    .in_ready  (rx_rdy),
    .in_data   (rsh_r),
    .out_valid (rx_v),
    .out_ready (rx_pop),
    .out_data  (rx_d)
  );

  // ----------------------------------------
  // Sample-rate generator
  // ----------------------------------------
  // Master roles
  assign master  = ctrl_r.transmit_clock_direction && ctrl_r.transmit_select_direction;
  assign m11     = (ctrl_r.clock_stop_mode == CSTOP_FULL);
  assign eff_src = master ? ctrl_r.generator_source_select : 1'b1;
  assign eff_div = master ? ctrl_r.generator_divider : SLAVE_DIV;

  // High phase length
  // Divider zero would need half ticks; one tick per phase instead.
  always_comb begin
    if (eff_div == 8'h00) begin
      hi_len = 8'h01;
    end else if (!eff_div[0]) begin
      hi_len = (eff_div >> 1) + 8'h01;
    end else begin
      hi_len = 8'((9'(eff_div) + 9'h001) >> 1);
    end
  end

  always_comb begin
    if (eff_div == 8'h00) begin
      lo_len = 8'h01;
    end else if (!eff_div[0]) begin
      lo_len = eff_div >> 1;
    end else begin
      lo_len = 8'((9'(eff_div) + 9'h001) >> 1);
    end
  end

  assign per_len = hi_len + lo_len;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gdiv_r     <= '0;
      src_prev_r <= 1'b0;
    end else begin
      gdiv_r     <= (gdiv_r == GEN_TICK_LAST) ? 2'h0 : gdiv_r + 2'h1;
      src_prev_r <= generator_source_clock;
    end
  end

  assign tick = eff_src ? (gdiv_r == GEN_TICK_LAST)
                        : (generator_source_clock && !src_prev_r);

  // ----------------------------------------
  // Slave-side pin view
  // ----------------------------------------
  // Active-low selects inverted
  assign sel    = transmit_frame_select ^ ctrl_r.transmit_select_polarity;
  assign rsel   = receive_frame_select ^ ctrl_r.receive_select_polarity;
  assign s_lvl  = transmit_serial_clock ^ !ctrl_r.transmit_clock_polarity;
  assign s_rise = s_lvl && !sclk_prev_r;
  assign s_fall = !s_lvl && sclk_prev_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclk_prev_r <= 1'b1;
    end else begin
      sclk_prev_r <= s_lvl;
    end
  end

  // ----------------------------------------
  // Transfer engine
  // ----------------------------------------
  // Word length from parameter, MSB first
  assign last_bit = (bit_r == 8'(WORD_W - 1));
  assign tx_pop   = (state_r == ST_IDLE) && ctrl_r.enable && tx_v
                    && (master ? (rx_rdy && tick) : sel);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r   <= ST_IDLE;
      cnt_r     <= '0;
      bit_r     <= '0;
      tsh_r     <= '0;
      rsh_r     <= '0;
      lvl_r     <= 1'b1;
      act_r     <= 1'b0;
      dx_r      <= 1'b0;
      dx_en_r   <= 1'b0;
      first_r   <= 1'b0;
      rx_push_r <= 1'b0;
    end else begin
      rx_push_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          lvl_r   <= 1'b1;
          dx_en_r <= 1'b0;
          bit_r   <= '0;
          // Select before first edge
          // Start on a tick so the lead is whole ticks
          if (ctrl_r.enable && master && tx_v && rx_rdy && tick) begin
            tsh_r   <= tx_d;
            act_r   <= 1'b1;
            // Lead from select to first fall
            cnt_r   <= m11 ? per_len : hi_len;
            state_r <= ST_LEAD;
          end else if (ctrl_r.enable && !master && sel) begin
            tsh_r   <= tx_v ? tx_d : '0;
            dx_r    <= tx_v ? tx_d[WORD_W-1] : 1'b0;
            dx_en_r <= 1'b1;
            first_r <= 1'b1;
            state_r <= ST_SLV;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            cnt_r <= cnt_r - 8'h01;
            if (m11 && cnt_r == hi_len + 8'h01) begin
              dx_en_r <= 1'b1;
              dx_r    <= tsh_r[WORD_W-1];
            end
            if (cnt_r == 8'h01) begin
              lvl_r   <= 1'b0;
              cnt_r   <= lo_len;
              state_r <= ST_LOW;
              if (!m11) begin
                dx_en_r <= 1'b1;
                dx_r    <= tsh_r[WORD_W-1];
              end
            end
          end
        end
        ST_LOW: begin
          if (tick) begin
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
              lvl_r <= 1'b1;
              rsh_r <= {rsh_r[WORD_W-2:0], serial_data_in};
              bit_r <= bit_r + 8'h01;
              if (last_bit) begin
                cnt_r   <= m11 ? hi_len : per_len;
                state_r <= ST_TAIL;
                if (m11) begin
                  dx_en_r <= 1'b0;
                end
              end else begin
                cnt_r   <= hi_len;
                state_r <= ST_HIGH;
                if (m11) begin
                  tsh_r <= tsh_r << 1;
                  dx_r  <= tsh_r[WORD_W-2];
                end
              end
            end
          end
        end
        ST_HIGH: begin
          if (tick) begin
            cnt_r <= cnt_r - 8'h01;
            if (cnt_r == 8'h01) begin
              lvl_r   <= 1'b0;
              cnt_r   <= lo_len;
              state_r <= ST_LOW;
              if (!m11) begin
                tsh_r <= tsh_r << 1;
                dx_r  <= tsh_r[WORD_W-2];
              end
            end
          end
        end
        ST_TAIL: begin
          if (tick) begin
            cnt_r <= cnt_r - 8'h01;
            // Release one high phase after last rise
            if (!m11 && cnt_r == lo_len + 8'h01) begin
              dx_en_r <= 1'b0;
            end
            if (cnt_r == 8'h01) begin
              dx_en_r   <= 1'b0;
              act_r     <= 1'b0;
              rx_push_r <= 1'b1;
              state_r   <= ST_IDLE;
            end
          end
        end
        ST_SLV: begin
          if (!sel || !ctrl_r.enable) begin
            dx_en_r <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            // Receive word lost when the buffer is full
            if ((m11 ? s_fall : s_rise) && rsel) begin
              rsh_r <= {rsh_r[WORD_W-2:0], serial_data_in};
              bit_r <= last_bit ? 8'h00 : bit_r + 8'h01;
              rx_push_r <= last_bit;
            end
            if (m11 ? s_rise : s_fall) begin
              if (first_r && !m11) begin
                first_r <= 1'b0;
              end else begin
                tsh_r <= tsh_r << 1;
                dx_r  <= tsh_r[WORD_W-2];
              end
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      transmit_serial_clock_drv  <= 1'b0;
      transmit_serial_clock_oe_n <= 1'b1;
      transmit_frame_select_drv  <= 1'b0;
      transmit_frame_select_oe_n <= 1'b1;
      serial_data_out            <= 1'b0;
      serial_data_out_oe_n       <= 1'b1;
    end else begin
      transmit_serial_clock_drv  <= lvl_r ^ !ctrl_r.transmit_clock_polarity;
      // Direction bit zero makes pin input
      transmit_serial_clock_oe_n <= !ctrl_r.transmit_clock_direction;
      transmit_frame_select_drv  <= act_r ^ ctrl_r.transmit_select_polarity;
      transmit_frame_select_oe_n <= !ctrl_r.transmit_select_direction;
      serial_data_out            <= dx_r;
      serial_data_out_oe_n       <= !dx_en_r;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state; a data write waits while the transmit buffer is full.
  assign acc     = psel && penable && !pready_r;
  // Writes land at the edge that sees pready high
  assign tx_in_v = psel && penable && pready_r && pwrite && (paddr == TXDATA_ADDR);
  assign rx_pop  = acc && !pwrite && (paddr == RXDATA_ADDR);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (psel && penable && pready_r && pwrite && paddr == CTRL_ADDR) begin
      ctrl_r <= spcs_ctrl_t'(pwdata[$bits(spcs_ctrl_t)-1:0]);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= acc && !(pwrite && paddr == TXDATA_ADDR && !tx_in_rdy);
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
      if (acc) begin
        unique case (paddr)
          CTRL_ADDR:   prdata_r <= 32'(ctrl_r);
          STATUS_ADDR: begin
            prdata_r[ST_BUSY]     <= (state_r != ST_IDLE);
            prdata_r[ST_TX_FULL]  <= !tx_in_rdy;
            prdata_r[ST_TX_EMPTY] <= !tx_v;
            prdata_r[ST_RX_VALID] <= rx_v;
            prdata_r[ST_RX_FULL]  <= !rx_rdy;
          end
          TXDATA_ADDR: prdata_r <= '0;
          RXDATA_ADDR: prdata_r <= rx_v ? 32'(rx_d) : '0;
          default:     pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_quarter_tick_rate: assert property (
    (tick && eff_src) ##1 eff_src [*4]
    |-> tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3))
    else $error("generator tick not every four clocks");
  a_phase_sum: assert property (
    (eff_div != 8'h00) |-> (per_len == eff_div + 8'h01))
    else $error("serial clock period wrong");
  a_high_phase_load: assert property (
    (state_r == ST_LOW && tick && cnt_r == 8'h01 && !last_bit)
    |=> state_r == ST_HIGH && cnt_r == $past(hi_len))
    else $error("high phase length wrong");
  a_low_phase_load: assert property (
    (state_r == ST_HIGH && tick && cnt_r == 8'h01)
    |=> state_r == ST_LOW && cnt_r == $past(lo_len))
    else $error("low phase length wrong");
  a_slave_gen_fixed: assert property (
    (!master && tick) ##1 !master [*4]
    |-> tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3))
    else $error("slave generator not quarter clock");
  a_master_sel_low: assert property (
    (master && ctrl_r.transmit_select_polarity && act_r && $stable(ctrl_r))
    |=> !transmit_frame_select_drv && !transmit_frame_select_oe_n)
    else $error("master select not active low");
  a_slave_sel_inv: assert property (
    (state_r == ST_IDLE && ctrl_r.enable && !master
     && ctrl_r.transmit_select_polarity && !transmit_frame_select)
    |=> state_r == ST_SLV)
    else $error("slave ignored low select");
  a_slave_pins_in: assert property (
    (!ctrl_r.transmit_clock_direction && !ctrl_r.transmit_select_direction)
    |=> transmit_serial_clock_oe_n && transmit_frame_select_oe_n)
    else $error("slave drives clock or select");
  a_lead_length: assert property (
    (state_r == ST_IDLE && $past(state_r) == ST_IDLE) ##1 state_r == ST_LEAD
    |-> cnt_r == (m11 ? $past(per_len) : $past(hi_len)))
    else $error("lead time wrong");
  a_full_tail_off: assert property (
    (state_r == ST_TAIL && m11) |-> !dx_en_r)
    else $error("data still driven in tail");
  a_slave_release: assert property (
    (state_r == ST_SLV && !sel) |=> !dx_en_r ##1 serial_data_out_oe_n)
    else $error("slave kept driving after deselect");
  a_slave_drive_soon: assert property (
    (state_r == ST_IDLE && ctrl_r.enable && !master && sel)
    |-> ##[1:2] !serial_data_out_oe_n)
    else $error("slave data not driven in time");

  c_master_word: cover property (state_r == ST_TAIL && master ##[1:300] state_r == ST_IDLE);
  c_slave_word:  cover property (state_r == ST_SLV && rx_push_r);
  c_tx_stall:    cover property (acc && pwrite && paddr == TXDATA_ADDR && !tx_in_rdy);
  c_full_mode:   cover property (m11 && state_r == ST_TAIL);
endmodule

// >>> verification/spcs_slave_model.sv
// Far-end serial slave used while the port runs as master.
// Assumes pins seen once per mclk, select active low, clock polarity 1.
`timescale 1ns/1ps

module spcs_slave_model (
  input  wire logic       mclk,
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic       late,
  input  wire logic [7:0] word,
  output logic            miso,
  output logic [7:0]      rx
);
  logic       ps  = 1'h1;
  logic       act = 1'h0;
  logic       nf  = 1'h0;
  logic [7:0] sh  = 8'h00;

  initial begin
    miso = 1'h0;
    rx   = 8'h00;
  end

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  always @(posedge mclk) begin
    ps <= sclk;
    // MSB first; released line toggles so no stale bit survives
    if (sel_n) begin
      act  <= 1'h0;
      miso <= ~miso;
    // first bit ready before the enabling edge
    end else if (!act) begin
      act  <= 1'h1;
      nf   <= 1'h0;
      miso <= word[7];
      sh   <= {word[6:0], 1'h0};
    end else if (sclk != ps) begin
      if (sclk ^ late) begin
        rx <= {rx[6:0], mosi};
      end else if (late || nf) begin
        miso <= sh[7];
        sh   <= {sh[6:0], 1'h0};
      end
      if (!sclk) begin
        nf <= 1'h1;
      end
    end
  end
endmodule

// >>> verification/spcs_top_tb_top.sv
// Self-checking bench for the clock-stop serial port.
// Assumes an APB master here and the far-end model beside it.
`timescale 1ns/1ps

module spcs_top_tb_top;
  import spcs_pkg::*;
  logic        mclk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, tb_clk = 1'h1, tb_sel = 1'h1, rfs = 1'h1;
  logic        tb_mosi = 1'h0, mst = 1'h1, late = 1'h0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [7:0]  pw = 8'h00;
  wire  [31:0] prdata;
  wire  [7:0]  prx;
  wire         pready, pslverr, clk_drv, clk_oe_n, sel_drv, sel_oe_n;
  wire         dout, dout_oe_n, miso, sclk, sel, din;
  int          fails = 0, n_compared = 0;
  logic        gsrc = 1'h0;
  localparam int GSRC_P = 2;

  always #4 mclk = ~mclk;
  // External generator source: one rise every two mclk
  always @(posedge mclk) gsrc <= ~gsrc;
  // Pad resolution: device wins while its enable is low
  assign sclk = clk_oe_n ? tb_clk : clk_drv;
  assign sel  = sel_oe_n ? tb_sel : sel_drv;
  assign din  = mst ? miso : tb_mosi;

  spcs_top spcs_top_inst (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .generator_source_clock(gsrc),
    .transmit_serial_clock(sclk), .transmit_serial_clock_drv(clk_drv),
    .transmit_serial_clock_oe_n(clk_oe_n), .transmit_frame_select(sel),
    .transmit_frame_select_drv(sel_drv), .transmit_frame_select_oe_n(sel_oe_n),
    .receive_frame_select(rfs), .serial_data_out(dout),
    .serial_data_out_oe_n(dout_oe_n), .serial_data_in(din));

  spcs_slave_model spcs_slave_model_inst (
    .mclk(mclk), .sclk(sclk), .sel_n(sel), .mosi(dout), .late(late),
    .word(pw), .miso(miso), .rx(prx));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  function automatic logic [31:0] cw(input logic m, input logic s, input logic [7:0] d,
                                     input logic [1:0] md);
    return 32'(spcs_ctrl_t'({3'h7, 1'h0, m, 1'h0, m, 1'h1, md, d, s}));
  endfunction

  task end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    chk({clk_oe_n, sel_oe_n, dout_oe_n}, 32'h7);
    apb(1'h0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, STATUS_ADDR, 32'h0);
    chk(rd, 32'h1 << ST_TX_EMPTY);
    apb(1'h0, 12'h010, 32'h0);
    chk(err, 32'h1);
  endtask

  // Expected phases in generator ticks; p mclk per tick
  task t_master(input logic s, input logic [7:0] d, input logic [1:0] md, input int h,
                input int l);
    int n, lo, p;
    time t0;
    logic [7:0] w;
    p = s ? GEN_SRC_DIV_P : GSRC_P;
    w = 8'hA5 ^ d;
    mst <= 1'h1;
    late <= md[0];
    pw <= ~w;
    apb(1'h1, CTRL_ADDR, cw(1'h1, s, d, md));
    apb(1'h1, TXDATA_ADDR, {24'h0, w});
    chk({clk_oe_n, sel_oe_n}, 32'h0);
    n = 0;
    while (sel_drv !== 1'h0) @(posedge mclk);
    t0 = $time;
    while (clk_drv !== 1'h0) begin @(posedge mclk); n++; end
    chk(n, md[0] ? p * (h + l) : p * h);
    lo = 0;
    while (clk_drv !== 1'h1) begin @(posedge mclk); lo++; end
    chk(lo, p * l);
    n = 0;
    while (clk_drv !== 1'h0) begin @(posedge mclk); n++; end
    chk(n, p * h);
    chk(n + lo, p * (1 + d));
    while (sel_drv !== 1'h1) @(posedge mclk);
    // Whole frame is lead, eight bits and tail: nine periods in both modes
    chk(32'(($time - t0) / CLK_PERIOD_NS), 9 * p * (1 + d));
    chk(dout_oe_n, 32'h1);
    apb(1'h0, RXDATA_ADDR, 32'h0);
    chk(rd, {24'h0, ~w});
    chk(prx, w);
  endtask

  task t_slave;
    int n;
    logic [7:0] got;
    mst <= 1'h0;
    // Source bit cleared: slave must still run on the quarter clock
    apb(1'h1, CTRL_ADDR, cw(1'h0, 1'h0, SLAVE_DIV, CSTOP_HALF));
    apb(1'h1, TXDATA_ADDR, 32'h96);
    chk({clk_oe_n, sel_oe_n}, 32'h3);
    tb_sel <= 1'h0;
    rfs <= 1'h0;
    n = 0;
    @(posedge mclk);
    while (dout_oe_n !== 1'h0) begin @(posedge mclk); n++; end
    chk(n <= SLV_DX_MAX_CYC, 32'h1);
    chk(dout, 32'h1);
    for (int i = 0; i < 8; i++) begin
      tb_clk <= 1'h0;
      tb_mosi <= 1'(8'h5A >> (7 - i));
      repeat (4) @(posedge mclk);
      got = {got[6:0], dout};
      tb_clk <= 1'h1;
      repeat (4) @(posedge mclk);
    end
    chk(got, 32'h96);
    tb_sel <= 1'h1;
    rfs <= 1'h1;
    repeat (4) @(posedge mclk);
    chk(dout_oe_n, 32'h1);
    apb(1'h0, RXDATA_ADDR, 32'h0);
    chk(rd, 32'h5A);
  endtask

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'h0;
    t_reset;
    t_master(1'h1, 8'h01, CSTOP_HALF, 1, 1);
    t_master(1'h1, 8'h02, CSTOP_HALF, 2, 1);
    t_master(1'h0, 8'h03, CSTOP_HALF, 2, 2);
    t_master(1'h1, 8'h02, CSTOP_FULL, 2, 1);
    t_master(1'h1, 8'h03, CSTOP_FULL, 2, 2);
    t_slave;
    end_of_test;
  end

  // Whole run needs about 700 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    end_of_test;
  end
endmodule
